// >>> hw/csp_defs.svh
// offsets, field positions, reset values and limits of the core registers
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// ==========================================================
// register offsets
`define CSP_OFS_SP    8'h81
`define CSP_OFS_DPL   8'h82
`define CSP_OFS_DPH   8'h83
`define CSP_OFS_POWER_CONTROL  8'h87
`define CSP_OFS_PSW   8'hD0
`define CSP_OFS_ACC   8'hE0
`define CSP_OFS_B     8'hF0

// ==========================================================
// reset values
`define CSP_SP_RST    8'h07
`define CSP_DPL_RST   8'h00
`define CSP_DPH_RST   8'h00
`define CSP_POWER_CONTROL_RST  8'h00
`define CSP_PSW_RST   8'h00
`define CSP_ACC_RST   8'h00
`define CSP_B_RST     8'h00

// ==========================================================
// status word fields
`define CSP_PSW_CY    7
`define CSP_PSW_AC    6
`define CSP_PSW_F0    5
`define CSP_PSW_RS1   4
`define CSP_PSW_RS0   3
`define CSP_PSW_OV    2
`define CSP_PSW_F1    1
`define CSP_PSW_PAR   0

// ==========================================================
// power control fields
`define CSP_POWER_CONTROL_IDLE 0
`define CSP_POWER_CONTROL_STOP 1
`define CSP_POWER_CONTROL_RSV_LO 2
`define CSP_POWER_CONTROL_RSV_HI 7

// ==========================================================
// limits
`define CSP_MUL_MAX   16'h00FF

`endif

// >>> hw/csp_pkg.sv
// types shared by the core status and power mode block
package csp_pkg;

   // ==========================================================
   // power modes
   typedef enum logic [1:0] {
      CSP_RUN  = 2'b00,
      CSP_IDLE = 2'b01,
      CSP_STOP = 2'b10
   } csp_mode_t;

   // ==========================================================
   // arithmetic operations that touch the flags
   typedef enum logic [2:0] {
      CSP_OP_NONE  = 3'b000,
      CSP_OP_ADD   = 3'b001,
      CSP_OP_ADDC  = 3'b010,
      CSP_OP_SUBB  = 3'b011,
      CSP_OP_MUL   = 3'b100,
      CSP_OP_DIV   = 3'b101,
      CSP_OP_OTHER = 3'b110
   } csp_alu_op_t;

   // ==========================================================
   // complete state of the block
   typedef struct packed {
      logic [7:0] sp;
      logic [7:0] data_pointer_low;
      logic [7:0] data_pointer_high;
      logic       cy;
      logic       ac;
      logic       f0;
      logic [1:0] rs;
      logic       ov;
      logic       f1;
      logic       par;
      logic [7:0] acc;
      logic [7:0] b;
      logic [5:0] power_control_rsv;
      logic       pend_idle;
      logic       pend_stop;
      csp_mode_t  mode;
      logic [7:0] rdata;
      logic [7:0] stk_addr;
      logic       cpu_en;
      logic       per_en;
      logic       osc_en;
      logic       wake;
      logic       core_rst;
   } csp_state_t;

endpackage

// >>> hw/csp_core_regs.sv
// core status registers and idle/stop power mode control
//
// Behaviour
// - stack pointer increments before each pushed byte is stored
// - every reset leaves the stack pointer at 0x07
// - low and high data pointer bytes form one 16-bit pointer
// - carry set on add carry or subtract borrow, else cleared
// - half carry set on nibble carry or borrow, else cleared
// - two bank bits select register bank base 0x00,0x08,0x10,0x18
// - overflow set on signed overflow, product above 255, zero divide
// - add, addc, subb, mul, div clear overflow otherwise
// - parity bit is read-only odd parity of the accumulator
// - status bits 5 and 1 are plain software flags
// - idle select write halts the processor after that instruction
// - idle keeps all state; only the processor clock stops
// - enabled interrupt in idle clears idle and restarts processor
// - after the interrupt return execution resumes after idle write
// - reset ending idle or stop runs normal reset from 0x0000
// - enabled watchdog reset can end idle mode
// - stop select write enters stop after that instruction
// - stop halts oscillator, processor and digital peripherals
// - stop ignores interrupts; only a reset ends it
// - missing clock detector reset ends stop; disable for long stops
// - idle and stop select bits always read back as 0
`timescale 1ns/1ns

`include "csp_defs.svh"

module csp_core_regs
   import csp_pkg::*;
(
   input  logic        sys_clk_i,
   input  logic        resetn_i,
   // register port from the processor
   input  logic [7:0]  sfr_addr_i,
   input  logic        sfr_wr_i,
   input  logic        sfr_rd_i,
   input  logic [7:0]  sfr_wdata_i,
   output logic [7:0]  sfr_rdata_o,
   // stack operations
   input  logic        push_i,
   input  logic        pop_i,
   output logic [7:0]  stack_ptr_o,
   output logic [7:0]  stack_addr_o,
   // arithmetic
   input  csp_alu_op_t alu_op_i,
   input  logic [7:0]  alu_operand_i,
   // power control
   input  logic        instr_done_i,
   input  logic        irq_pending_i,
   input  logic        wdt_reset_i,
   input  logic        mcd_reset_i,
   // views of the registers
   output logic [15:0] data_ptr_o,
   output logic [7:0]  bank_base_o,
   output logic [7:0]  psw_o,
   output logic [7:0]  acc_o,
   output logic [7:0]  b_o,
   // clock gating and restart
   output logic        cpu_clk_en_o,
   output logic        periph_clk_en_o,
   output logic        osc_en_o,
   output logic        idle_wake_o,
   output logic        core_reset_o
);

   // ==========================================================
   // functions
   function automatic csp_state_t rst_state();
      csp_state_t r;
      r          = '0;
      r.sp       = `CSP_SP_RST;
      r.data_pointer_low      = `CSP_DPL_RST;
      r.data_pointer_high      = `CSP_DPH_RST;
      r.acc      = `CSP_ACC_RST;
      r.b        = `CSP_B_RST;
      r.par      = ^r.acc;
      r.mode     = CSP_RUN;
      r.cpu_en   = 1'b1;
      r.per_en   = 1'b1;
      r.osc_en   = 1'b1;
      return r;
   endfunction

   function automatic logic [7:0] psw_byte(input csp_state_t s);
      logic [7:0] p;
      p                = '0;
      p[`CSP_PSW_CY]   = s.cy;
      p[`CSP_PSW_AC]   = s.ac;
      p[`CSP_PSW_F0]   = s.f0;
      p[`CSP_PSW_RS1]  = s.rs[1];
      p[`CSP_PSW_RS0]  = s.rs[0];
      p[`CSP_PSW_OV]   = s.ov;
      p[`CSP_PSW_F1]   = s.f1;
      p[`CSP_PSW_PAR]  = s.par;
      return p;
   endfunction

   // ==========================================================
   // state
   csp_state_t s_q;
   csp_state_t s_d;

   always_comb begin
      logic [8:0]  sum9;
      logic [4:0]  nib5;
      logic [8:0]  cin9;
      logic [4:0]  cin5;
      logic [15:0] prod;
      logic [7:0]  power_control_rd;
      s_d      = s_q;
      sum9     = '0;
      nib5     = '0;
      cin9     = '0;
      cin5     = '0;
      prod     = '0;
      power_control_rd  = {s_q.power_control_rsv, 2'b00};
      s_d.wake     = 1'b0;
      s_d.core_rst = 1'b0;

      if (wdt_reset_i || mcd_reset_i) begin
         // internal reset: same values as the pin reset
         s_d          = rst_state();
         s_d.core_rst = 1'b1;
      end else begin
         case (s_q.mode)
            CSP_RUN: begin
               // ---- register reads, before this cycle's writes
               if (sfr_rd_i) begin
                  case (sfr_addr_i)
                     `CSP_OFS_SP:   s_d.rdata = s_q.sp;
                     `CSP_OFS_DPL:  s_d.rdata = s_q.data_pointer_low;
                     `CSP_OFS_DPH:  s_d.rdata = s_q.data_pointer_high;
                     // select bits always read low
                     `CSP_OFS_POWER_CONTROL: s_d.rdata = power_control_rd;
                     `CSP_OFS_PSW:  s_d.rdata = psw_byte(s_q);
                     `CSP_OFS_ACC:  s_d.rdata = s_q.acc;
                     `CSP_OFS_B:    s_d.rdata = s_q.b;
                     default:       s_d.rdata = 8'h00;
                  endcase
               end

               // ---- register writes
               if (sfr_wr_i) begin
                  case (sfr_addr_i)
                     `CSP_OFS_SP:  s_d.sp  = sfr_wdata_i;
                     `CSP_OFS_DPL: s_d.data_pointer_low = sfr_wdata_i;
                     `CSP_OFS_DPH: s_d.data_pointer_high = sfr_wdata_i;
                     `CSP_OFS_POWER_CONTROL: begin
                        s_d.power_control_rsv = sfr_wdata_i[`CSP_POWER_CONTROL_RSV_HI:
                                                   `CSP_POWER_CONTROL_RSV_LO];
                        if (sfr_wdata_i[`CSP_POWER_CONTROL_IDLE]) begin
                           s_d.pend_idle = 1'b1;
                        end
                        if (sfr_wdata_i[`CSP_POWER_CONTROL_STOP]) begin
                           s_d.pend_stop = 1'b1;
                        end
                     end
                     `CSP_OFS_PSW: begin
                        // parity is not writable
                        s_d.cy = sfr_wdata_i[`CSP_PSW_CY];
                        s_d.ac = sfr_wdata_i[`CSP_PSW_AC];
                        s_d.f0 = sfr_wdata_i[`CSP_PSW_F0];
                        s_d.rs = {sfr_wdata_i[`CSP_PSW_RS1],
                                  sfr_wdata_i[`CSP_PSW_RS0]};
                        s_d.ov = sfr_wdata_i[`CSP_PSW_OV];
                        s_d.f1 = sfr_wdata_i[`CSP_PSW_F1];
                     end
                     `CSP_OFS_ACC: s_d.acc = sfr_wdata_i;
                     `CSP_OFS_B:   s_d.b   = sfr_wdata_i;
                     default: begin
                        s_d.rdata = s_d.rdata;
                     end
                  endcase
               end

               // ---- stack, takes priority over a write to the pointer
               if (push_i) begin
                  s_d.sp       = s_q.sp + 8'h01;
                  s_d.stk_addr = s_q.sp + 8'h01;
               end else if (pop_i) begin
                  s_d.stk_addr = s_q.sp;
                  s_d.sp       = s_q.sp - 8'h01;
               end

               // ---- arithmetic, takes priority over register writes
               cin9 = {8'h00, s_q.cy};
               cin5 = {4'h0, s_q.cy};
               case (alu_op_i)
                  CSP_OP_ADD, CSP_OP_ADDC: begin
                     if (alu_op_i == CSP_OP_ADD) begin
                        cin9 = '0;
                        cin5 = '0;
                     end
                     sum9 = {1'b0, s_q.acc} + {1'b0, alu_operand_i} + cin9;
                     nib5 = {1'b0, s_q.acc[3:0]}
                          + {1'b0, alu_operand_i[3:0]} + cin5;
                     s_d.acc = sum9[7:0];
                     s_d.cy  = sum9[8];
                     s_d.ac  = nib5[4];
                     s_d.ov  = (s_q.acc[7] == alu_operand_i[7])
                             && (sum9[7] != s_q.acc[7]);
                  end
                  CSP_OP_SUBB: begin
                     sum9 = {1'b0, s_q.acc} - {1'b0, alu_operand_i} - cin9;
                     nib5 = {1'b0, s_q.acc[3:0]}
                          - {1'b0, alu_operand_i[3:0]} - cin5;
                     s_d.acc = sum9[7:0];
                     s_d.cy  = sum9[8];
                     s_d.ac  = nib5[4];
                     s_d.ov  = (s_q.acc[7] != alu_operand_i[7])
                             && (sum9[7] != s_q.acc[7]);
                  end
                  CSP_OP_MUL: begin
                     prod    = s_q.acc * s_q.b;
                     s_d.acc = prod[7:0];
                     s_d.b   = prod[15:8];
                     s_d.cy  = 1'b0;
                     s_d.ac  = 1'b0;
                     s_d.ov  = prod > `CSP_MUL_MAX;
                  end
                  CSP_OP_DIV: begin
                     s_d.cy = 1'b0;
                     s_d.ac = 1'b0;
                     if (s_q.b == 8'h00) begin
                        // operands left untouched on a zero divisor
                        s_d.ov = 1'b1;
                     end else begin
                        s_d.acc = s_q.acc / s_q.b;
                        s_d.b   = s_q.acc % s_q.b;
                        s_d.ov  = 1'b0;
                     end
                  end
                  CSP_OP_OTHER: begin
                     s_d.cy = 1'b0;
                     s_d.ac = 1'b0;
                  end
                  default: begin
                     s_d.cy = s_d.cy;
                  end
               endcase

               // ---- power mode entry when the writing instruction ends
               if (instr_done_i && (s_d.pend_stop || s_d.pend_idle)) begin
                  if (s_d.pend_stop) begin
                     s_d.mode   = CSP_STOP;
                     s_d.cpu_en = 1'b0;
                     s_d.per_en = 1'b0;
                     s_d.osc_en = 1'b0;
                  end else begin
                     s_d.mode   = CSP_IDLE;
                     s_d.cpu_en = 1'b0;
                  end
                  s_d.pend_stop = 1'b0;
                  s_d.pend_idle = 1'b0;
               end
            end

            CSP_IDLE: begin
               // registers hold; peripherals keep their clock
               if (irq_pending_i) begin
                  s_d.mode   = CSP_RUN;
                  s_d.cpu_en = 1'b1;
                  // no restart: the processor resumes its own program
                  // counter, so the return lands after the idle write
                  s_d.wake   = 1'b1;
               end
            end

            CSP_STOP: begin
               // interrupts have no effect here
               s_d.mode = CSP_STOP;
            end

            default: begin
               s_d = rst_state();
            end
         endcase
      end

      s_d.par = ^s_d.acc;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         s_q          <= rst_state();
         s_q.core_rst <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs, all taken from the state register
   assign sfr_rdata_o     = s_q.rdata;
   assign stack_ptr_o     = s_q.sp;
   assign stack_addr_o    = s_q.stk_addr;
   assign data_ptr_o      = {s_q.data_pointer_high, s_q.data_pointer_low};
   assign bank_base_o     = {3'b000, s_q.rs, 3'b000};
   assign psw_o           = psw_byte(s_q);
   assign acc_o           = s_q.acc;
   assign b_o             = s_q.b;
   assign cpu_clk_en_o    = s_q.cpu_en;
   assign periph_clk_en_o = s_q.per_en;
   assign osc_en_o        = s_q.osc_en;
   assign idle_wake_o     = s_q.wake;
   assign core_reset_o    = s_q.core_rst;

endmodule

// >>> verif/csp_core_regs_checker.sv
// concurrent checks on the ports of the core status and power mode block
`timescale 1ns/1ns
`include "csp_defs.svh"
module csp_core_regs_checker
   import csp_pkg::*;
(
   input wire logic        sys_clk_i,
   input wire logic        resetn_i,
   input wire logic [7:0]  sfr_addr_i,
   input wire logic        sfr_wr_i,
   input wire logic        sfr_rd_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic [7:0]  sfr_rdata_o,
   input wire logic        push_i,
   input wire logic [7:0]  stack_ptr_o,
   input wire csp_alu_op_t alu_op_i,
   input wire logic [7:0]  acc_o,
   input wire logic [7:0]  b_o,
   input wire logic [7:0]  psw_o,
   input wire logic [7:0]  bank_base_o,
   input wire logic        instr_done_i,
   input wire logic        irq_pending_i,
   input wire logic        wdt_reset_i,
   input wire logic        mcd_reset_i,
   input wire logic        cpu_clk_en_o,
   input wire logic        periph_clk_en_o,
   input wire logic        osc_en_o,
   input wire logic        idle_wake_o,
   input wire logic        core_reset_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   logic irst;
   assign irst = wdt_reset_i | mcd_reset_i;
   // ==========================================================
   // assertions
   sp_reset_a: assert property (core_reset_o |->
      stack_ptr_o == `CSP_SP_RST && cpu_clk_en_o && osc_en_o)
      else $error("stack pointer not at reset value");
   push_inc_a: assert property (
      push_i && cpu_clk_en_o && !irst |=>
      stack_ptr_o == $past(stack_ptr_o) + 8'h01)
      else $error("push did not advance stack pointer");
   odd_parity_a: assert property (psw_o[0] == ^acc_o)
      else $error("parity flag wrong");
   bank_map_a: assert property (
      bank_base_o == {3'b000, psw_o[4:3], 3'b000})
      else $error("bank base wrong");
   mul_ov_a: assert property (
      alu_op_i == CSP_OP_MUL && cpu_clk_en_o && !irst |=>
      psw_o[7:6] == 2'b00 && psw_o[2] ==
      ({8'h00, $past(acc_o)} * {8'h00, $past(b_o)} > `CSP_MUL_MAX))
      else $error("multiply flags wrong");
   mode_read_a: assert property (sfr_rd_i && cpu_clk_en_o &&
      sfr_addr_i == `CSP_OFS_POWER_CONTROL |=> sfr_rdata_o[1:0] == 2'b00)
      else $error("mode select bits read nonzero");
   stop_hold_a: assert property (!osc_en_o && !irst |=>
      !osc_en_o && !cpu_clk_en_o && !periph_clk_en_o)
      else $error("stop left without reset");
   stop_entry_a: assert property (sfr_wr_i && instr_done_i &&
      cpu_clk_en_o && !irst && sfr_addr_i == `CSP_OFS_POWER_CONTROL &&
      sfr_wdata_i[1] |=> !osc_en_o && !cpu_clk_en_o)
      else $error("stop not entered");
   idle_wake_a: assert property (!cpu_clk_en_o && osc_en_o &&
      irq_pending_i && !irst |=> cpu_clk_en_o && idle_wake_o ##1 !idle_wake_o)
      else $error("idle wake wrong");
   // ==========================================================
   // covers
   c_wake: cover property (idle_wake_o);
   c_stop: cover property (!osc_en_o ##1 core_reset_o);
   c_ov: cover property (alu_op_i == CSP_OP_MUL ##1 psw_o[2]);
endmodule

bind csp_core_regs csp_core_regs_checker i_chk (
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_rdata_o(sfr_rdata_o), .push_i(push_i), .stack_ptr_o(stack_ptr_o),
   .alu_op_i(alu_op_i), .acc_o(acc_o), .b_o(b_o), .psw_o(psw_o),
   .bank_base_o(bank_base_o), .instr_done_i(instr_done_i),
   .irq_pending_i(irq_pending_i), .wdt_reset_i(wdt_reset_i),
   .mcd_reset_i(mcd_reset_i), .cpu_clk_en_o(cpu_clk_en_o),
   .periph_clk_en_o(periph_clk_en_o), .osc_en_o(osc_en_o),
   .idle_wake_o(idle_wake_o), .core_reset_o(core_reset_o));

// >>> verif/tb_csp_core_regs.sv
// self-checking bench for the core status and power mode block
`timescale 1ns/1ns
`include "csp_defs.svh"
module tb_csp_core_regs
   import csp_pkg::*;
;
   logic        sys_clk_i, resetn_i, sfr_wr_i, sfr_rd_i, push_i, pop_i;
   logic        instr_done_i, irq_pending_i, wdt_reset_i, mcd_reset_i;
   logic [7:0]  sfr_addr_i, sfr_wdata_i, alu_operand_i, sfr_rdata_o;
   logic [7:0]  stack_ptr_o, stack_addr_o, bank_base_o, psw_o, acc_o, b_o;
   logic [15:0] data_ptr_o;
   csp_alu_op_t alu_op_i;
   logic        cpu_clk_en_o, periph_clk_en_o, osc_en_o;
   logic        idle_wake_o, core_reset_o;
   int          bad_count, comparisons, n;

   csp_core_regs i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .push_i(push_i), .pop_i(pop_i), .stack_ptr_o(stack_ptr_o),
      .stack_addr_o(stack_addr_o), .alu_op_i(alu_op_i),
      .alu_operand_i(alu_operand_i), .instr_done_i(instr_done_i),
      .irq_pending_i(irq_pending_i), .wdt_reset_i(wdt_reset_i),
      .mcd_reset_i(mcd_reset_i), .data_ptr_o(data_ptr_o),
      .bank_base_o(bank_base_o), .psw_o(psw_o), .acc_o(acc_o), .b_o(b_o),
      .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
      .osc_en_o(osc_en_o), .idle_wake_o(idle_wake_o),
      .core_reset_o(core_reset_o));

   // ==========================================================
   // tasks
   task automatic print_verdict();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic dn);
      @(posedge sys_clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      instr_done_i <= dn;
      @(posedge sys_clk_i);
      sfr_wr_i <= 1'b0;
      instr_done_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      sfr_rd_i <= 1'b0;
      #1;
      chk({8'h00, sfr_rdata_o}, {8'h00, e});
   endtask
   task automatic stk(input logic ps, input logic pp, input logic [15:0] e);
      @(posedge sys_clk_i);
      push_i <= ps;
      pop_i <= pp;
      @(posedge sys_clk_i);
      push_i <= 1'b0;
      pop_i <= 1'b0;
      #1;
      chk({stack_ptr_o, stack_addr_o}, e);
   endtask
   // f holds expected carry, half carry and overflow
   task automatic alu(input csp_alu_op_t op, input logic [7:0] a, bv, pin,
                      input logic [7:0] ea, eb, input logic [2:0] f);
      wr(`CSP_OFS_ACC, a, 1'b0);
      wr(`CSP_OFS_B, bv, 1'b0);
      wr(`CSP_OFS_PSW, pin, 1'b0);
      @(posedge sys_clk_i);
      alu_op_i <= op;
      alu_operand_i <= bv;
      @(posedge sys_clk_i);
      alu_op_i <= CSP_OP_NONE;
      #1;
      chk({acc_o, b_o}, {ea, eb});
      chk({8'h00, psw_o}, {8'h00, f[2:1], 3'b000, f[0], 1'b0, ^ea});
   endtask
   task automatic ens(input logic [2:0] e);
      chk({13'h0000, cpu_clk_en_o, periph_clk_en_o, osc_en_o}, {13'h0000, e});
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #600000;
      bad_count++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      {resetn_i, sfr_wr_i, sfr_rd_i, push_i, pop_i} = 5'b00000;
      {instr_done_i, irq_pending_i, wdt_reset_i, mcd_reset_i} = 4'h0;
      {sfr_addr_i, sfr_wdata_i, alu_operand_i} = 24'h000000;
      alu_op_i = CSP_OP_NONE;
      bad_count = 0;
      comparisons = 0;
      repeat (20) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      rd(`CSP_OFS_SP, 8'h07);
      rd(`CSP_OFS_DPL, 8'h00);
      rd(`CSP_OFS_DPH, 8'h00);
      rd(`CSP_OFS_POWER_CONTROL, 8'h00);
      rd(`CSP_OFS_PSW, 8'h00);
      rd(`CSP_OFS_ACC, 8'h00);
      rd(`CSP_OFS_B, 8'h00);
      rd(8'h84, 8'h00);
      // this bench suspends the oscillator twice, in the two stop tests
      wr(`CSP_OFS_DPL, 8'h34, 1'b0);
      wr(`CSP_OFS_DPH, 8'h12, 1'b0);
      chk(data_ptr_o, 16'h1234);
      wr(`CSP_OFS_ACC, 8'h03, 1'b0);
      wr(`CSP_OFS_PSW, 8'h23, 1'b0);
      rd(`CSP_OFS_PSW, 8'h22);
      for (int i = 0; i < 4; i++) begin
         wr(`CSP_OFS_PSW, {3'b000, i[1:0], 3'b000}, 1'b0);
         chk({8'h00, bank_base_o}, {11'h000, i[1:0], 3'b000});
      end
      wr(`CSP_OFS_POWER_CONTROL, 8'hFC, 1'b0);
      rd(`CSP_OFS_POWER_CONTROL, 8'hFC);
      stk(1'b1, 1'b0, 16'h0808);
      stk(1'b0, 1'b1, 16'h0708);
      alu(CSP_OP_ADD, 8'h88,8'h88,8'h00, 8'h10,8'h88, 3'h7);
      alu(CSP_OP_ADD, 8'h01,8'h01,8'hC4, 8'h02,8'h01, 3'h0);
      alu(CSP_OP_ADDC, 8'h0F,8'h00,8'h80, 8'h10,8'h00, 3'h2);
      alu(CSP_OP_SUBB, 8'h00,8'h01,8'h00, 8'hFF,8'h01, 3'h6);
      alu(CSP_OP_MUL, 8'h10,8'h10,8'hC0, 8'h00,8'h01, 3'h1);
      alu(CSP_OP_DIV, 8'h07,8'h00,8'h00, 8'h07,8'h00, 3'h1);
      alu(CSP_OP_DIV, 8'h07,8'h02,8'hC4, 8'h03,8'h01, 3'h0);
      alu(CSP_OP_OTHER, 8'h55,8'h00,8'hC4, 8'h55,8'h00, 3'h1);
      // idle entry, refused write, interrupt wake
      wr(`CSP_OFS_ACC, 8'h5A, 1'b0);
      wr(`CSP_OFS_POWER_CONTROL, 8'h01, 1'b1);
      ens(3'b011);
      wr(`CSP_OFS_ACC, 8'hFF, 1'b0);
      chk({8'h00, acc_o}, 16'h005A);
      @(posedge sys_clk_i);
      irq_pending_i <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end while (idle_wake_o !== 1'b1 && n < 8);
      if (idle_wake_o !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
      chk({15'h0000, cpu_clk_en_o}, 16'h0001);
      @(posedge sys_clk_i);
      irq_pending_i <= 1'b0;
      #1;
      chk({15'h0000, idle_wake_o}, 16'h0000);
      rd(`CSP_OFS_ACC, 8'h5A);
      // watchdog ends idle
      wr(`CSP_OFS_SP, 8'h30, 1'b0);
      wr(`CSP_OFS_POWER_CONTROL, 8'h01, 1'b1);
      @(posedge sys_clk_i);
      wdt_reset_i <= 1'b1;
      @(posedge sys_clk_i);
      wdt_reset_i <= 1'b0;
      #1;
      chk({6'h00, core_reset_o, cpu_clk_en_o, stack_ptr_o},
          16'h0307);
      // both select bits, entry waits for instruction end
      wr(`CSP_OFS_POWER_CONTROL, 8'h03, 1'b0);
      ens(3'b111);
      rd(`CSP_OFS_POWER_CONTROL, 8'h00);
      @(posedge sys_clk_i);
      instr_done_i <= 1'b1;
      irq_pending_i <= 1'b1;
      @(posedge sys_clk_i);
      instr_done_i <= 1'b0;
      #1;
      ens(3'b000);
      repeat (5) @(posedge sys_clk_i);
      #1;
      ens(3'b000);
      @(posedge sys_clk_i);
      irq_pending_i <= 1'b0;
      mcd_reset_i <= 1'b1;
      @(posedge sys_clk_i);
      mcd_reset_i <= 1'b0;
      #1;
      chk({6'h00, core_reset_o, osc_en_o, stack_ptr_o},
          16'h0307);
      @(posedge sys_clk_i);
      #1;
      chk({15'h0000, core_reset_o}, 16'h0000);
      // stop entered in the writing cycle, left by the reset pin
      wr(`CSP_OFS_SP, 8'h44, 1'b0);
      wr(`CSP_OFS_POWER_CONTROL, 8'h03, 1'b1);
      ens(3'b000);
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk({5'h00, core_reset_o, cpu_clk_en_o, osc_en_o, stack_ptr_o},
          16'h0707);
      @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      @(posedge sys_clk_i);
      #1;
      chk({15'h0000, core_reset_o}, 16'h0000);
      rd(`CSP_OFS_SP, 8'h07);
      print_verdict();
   end
endmodule
